// ===== flash_self_access_defines.vh
`ifndef FLASH_SELF_ACCESS_DEFINES_VH
`define FLASH_SELF_ACCESS_DEFINES_VH

// Register byte offsets
`define OFF_ADDR_LO 8'h00
`define OFF_ADDR_HI 8'h04
`define OFF_DATA_LO 8'h08
`define OFF_DATA_HI 8'h0C
`define OFF_CTRL    8'h10
`define OFF_KEY     8'h14

// Control register bit positions
`define CTRL_RD     0
`define CTRL_GO     1
`define CTRL_ARM    2
`define CTRL_LOCKED 3
`define CTRL_SEL    7

// Unlock keys
`define KEY_FIRST   8'h55
`define KEY_SECOND  8'hAA

// Unlock progress codes
`define UNL_NONE    2'h0
`define UNL_FIRST   2'h1
`define UNL_READY   2'h2

// Timing
`define NOP_SLOTS   2'h2
`define LAST_SLOT   2'h1

// Reset values
`define CTRL_RESET  8'h00
`define BYTE_RESET  8'h00

`endif

// ===== program_flash_self_access.v
`include "flash_self_access_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module program_flash_self_access #(
  parameter ADDR_W         = 13,
  parameter DATA_W         = 14,
  parameter CLKS_PER_SLOT  = 4
) (
  // Clock and reset
  input  wire              clk_sys,
  input  wire              rst,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [7:0]        paddr,
  input  wire [31:0]       pwdata,
  output reg               pready,
  output reg  [31:0]       prdata,
  output reg               pslverr,
  // Configuration fuse pin, high allows writes
  input  wire              lockFuse,
  // Program flash array
  output reg  [ADDR_W-1:0] flashAddr,
  output reg               flashRdEn,
  input  wire [DATA_W-1:0] flashRdData,
  output reg               flashWrEn,
  output reg  [DATA_W-1:0] flashWrData,
  input  wire              flashWrDone,
  // Core control
  output reg               coreStall
);

  localparam HI_A = ADDR_W - 8;
  localparam HI_D = DATA_W - 8;

  localparam ST_IDLE  = 2'h0;
  localparam ST_READ  = 2'h1;
  localparam ST_SETUP = 2'h2;
  localparam ST_PROG  = 2'h3;

  reg  [7:0]   addrLo_q;
  reg  [HI_A-1:0] addrHi_q;
  reg  [7:0]   dataLo_q;
  reg  [HI_D-1:0] dataHi_q;
  reg          sel_q;
  reg          arm_q;
  reg  [1:0]   unlock_q;
  reg  [1:0]   state_q;
  reg  [1:0]   state_d;
  reg  [1:0]   slots_q;
  reg  [15:0]  div_q;
  reg          fuseMeta_q;
  reg          fuseSync_q;

  wire         access;
  wire         wrAcc;
  wire         slotTick;
  wire         ctrlWr;
  wire         keyWr;
  wire         rdReq;
  wire         goReq;
  wire         goOk;
  wire         mapped;
  wire         slotsDone;
  wire [7:0]   ctrlVal;
  wire         busy;
  wire         rdStart;

  // Fuse pin is asynchronous to the core clock
  // Reads as locked until the pin has been sampled twice
  always @(posedge clk_sys) begin
    if (rst) begin
      fuseMeta_q <= 1'b0;
      fuseSync_q <= 1'b0;
    end else begin
      fuseMeta_q <= lockFuse;
      fuseSync_q <= fuseMeta_q;
    end
  end

  // Instruction slot divider
  always @(posedge clk_sys) begin
    if (rst) begin
      div_q <= 16'h0000;
    end else if (div_q == CLKS_PER_SLOT - 1) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  assign slotTick = (div_q == CLKS_PER_SLOT - 1);

  // APB: one wait state, write lands when pready is seen
  assign access = psel & penable & pready;
  assign wrAcc  = access & pwrite;
  assign ctrlWr = wrAcc & (paddr == `OFF_CTRL);
  assign keyWr  = wrAcc & (paddr == `OFF_KEY);

  // Unmapped offsets answer with an error; a write there changes no register but clears unlock progress
  assign mapped = (paddr == `OFF_ADDR_LO) | (paddr == `OFF_ADDR_HI) |
                  (paddr == `OFF_DATA_LO) | (paddr == `OFF_DATA_HI) |
                  (paddr == `OFF_CTRL)    | (paddr == `OFF_KEY);

  // Requests while busy are dropped, not queued
  assign rdReq = ctrlWr & pwdata[`CTRL_RD] & (state_q == ST_IDLE);
  assign goReq = ctrlWr & pwdata[`CTRL_GO] & (state_q == ST_IDLE);
  assign rdStart = rdReq & pwdata[`CTRL_SEL];

  // Arm must already be set; the same write cannot arm and go
  assign goOk = goReq & arm_q
              & (unlock_q == `UNL_READY)
              & fuseSync_q
              & pwdata[`CTRL_SEL] & sel_q;

  assign slotsDone = slotTick & (slots_q == `LAST_SLOT);
  assign busy      = (state_q == ST_SETUP) | (state_q == ST_PROG);

  // Busy bits double as completion flags for firmware polling
  assign ctrlVal = {sel_q, 3'h0, ~fuseSync_q, arm_q, busy,
                    state_q == ST_READ};

  always @(posedge clk_sys) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata  <= 32'h00000000;
      if (psel & penable & ~pready & ~pwrite) begin
        case (paddr)
          `OFF_ADDR_LO: prdata[7:0]      <= addrLo_q;
          `OFF_ADDR_HI: prdata[HI_A-1:0] <= addrHi_q;
          `OFF_DATA_LO: prdata[7:0]      <= dataLo_q;
          `OFF_DATA_HI: prdata[HI_D-1:0] <= dataHi_q;
          `OFF_CTRL:    prdata[7:0]      <= ctrlVal;
          `OFF_KEY:     prdata           <= 32'h00000000;
          default:      prdata           <= 32'h00000000;
        endcase
      end
    end
  end

  // Unlock tracker; any other write breaks the sequence
  always @(posedge clk_sys) begin
    if (rst) begin
      unlock_q <= `UNL_NONE;
    end else if (keyWr) begin
      if (pwdata[7:0] == `KEY_FIRST) begin
        unlock_q <= `UNL_FIRST;
      end else if (pwdata[7:0] == `KEY_SECOND &&
                   unlock_q == `UNL_FIRST) begin
        unlock_q <= `UNL_READY;
      end else begin
        unlock_q <= `UNL_NONE;
      end
    end else if (wrAcc) begin
      unlock_q <= `UNL_NONE;
    end
  end

  // Address registers, firmware only
  always @(posedge clk_sys) begin
    if (rst) begin
      addrLo_q <= `BYTE_RESET;
      addrHi_q <= {HI_A{1'b0}};
    end else if (wrAcc && paddr == `OFF_ADDR_LO) begin
      addrLo_q <= pwdata[7:0];
    end else if (wrAcc && paddr == `OFF_ADDR_HI) begin
      addrHi_q <= pwdata[HI_A-1:0];
    end
  end

  // Control bits; arm may drop mid-write without effect
  always @(posedge clk_sys) begin
    if (rst) begin
      sel_q <= 1'b0;
      arm_q <= 1'b0;
    end else if (ctrlWr) begin
      sel_q <= pwdata[`CTRL_SEL];
      arm_q <= pwdata[`CTRL_ARM];
    end
  end

  // Data registers: fetched word or firmware writes
  always @(posedge clk_sys) begin
    if (rst) begin
      dataLo_q <= `BYTE_RESET;
      dataHi_q <= {HI_D{1'b0}};
    end else if (state_q == ST_READ && slotsDone) begin
      dataLo_q <= flashRdData[7:0];
      dataHi_q <= flashRdData[DATA_W-1:8];
    end else if (wrAcc && paddr == `OFF_DATA_LO) begin
      dataLo_q <= pwdata[7:0];
    end else if (wrAcc && paddr == `OFF_DATA_HI) begin
      dataHi_q <= pwdata[HI_D-1:0];
    end
  end

  // Sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (rdStart) begin
          state_d = ST_READ;
        end else if (goOk) begin
          state_d = ST_SETUP;
        end
      end
      ST_READ: begin
        if (slotsDone) begin
          state_d = ST_IDLE;
        end
      end
      ST_SETUP: begin
        if (slotsDone) begin
          state_d = ST_PROG;
        end
      end
      ST_PROG: begin
        // Length set by the array's done strobe
        if (flashWrDone) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // State register
  always @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Slot counter: two no-operation slots after start
  always @(posedge clk_sys) begin
    if (rst) begin
      slots_q <= 2'h0;
    end else if (state_q == ST_IDLE) begin
      slots_q <= `NOP_SLOTS;
    end else if (slotTick && slots_q != 2'h0) begin
      slots_q <= slots_q - 2'h1;
    end
  end

  // Flash array drive
  always @(posedge clk_sys) begin
    if (rst) begin
      flashAddr   <= {ADDR_W{1'b0}};
      flashRdEn   <= 1'b0;
      flashWrEn   <= 1'b0;
      flashWrData <= {DATA_W{1'b0}};
    end else begin
      // Frozen while an access runs so a late register write cannot retarget it
      if (state_q == ST_IDLE) begin
        flashAddr   <= {addrHi_q, addrLo_q};
        flashWrData <= {dataHi_q, dataLo_q};
      end
      flashRdEn   <= (state_d == ST_READ);
      flashWrEn   <= (state_d == ST_PROG);
    end
  end

  // Only the core halts; divider and peripherals keep going
  always @(posedge clk_sys) begin
    if (rst) begin
      coreStall <= 1'b0;
    end else begin
      coreStall <= (state_d == ST_PROG);
    end
  end

endmodule

`default_nettype wire

// ===== flash_array_model.sv
`timescale 1ns/1ns
`default_nettype none
module flash_array_model #(
  parameter ADDR_W = 13,
  parameter DATA_W = 14
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Array side
  input  wire logic [ADDR_W-1:0] flashAddr,
  input  wire logic              flashRdEn,
  output logic      [DATA_W-1:0] flashRdData,
  input  wire logic              flashWrEn,
  input  wire logic [DATA_W-1:0] flashWrData,
  output logic                   flashWrDone,
  // Programming length in clocks
  input  wire logic [7:0]        progLen
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0]        cnt_q;
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++)
      mem[i] = DATA_W'(i * 7 + 3);
  end
  // Outside a read the bus shows the complement, so stale data never passes
  assign flashRdData = flashRdEn ? mem[flashAddr] : ~mem[flashAddr];
  always @(posedge clk_sys) begin
    flashWrDone <= 1'b0;
    if (rst || !flashWrEn || flashWrDone)
      cnt_q <= 8'h00;
    else if (cnt_q == progLen) begin
      mem[flashAddr] <= flashWrData;
      flashWrDone <= 1'b1;
    end else
      cnt_q <= cnt_q + 8'h01;
  end
endmodule
`default_nettype wire

// ===== program_flash_self_access_sva.sv
`timescale 1ns/1ns
`default_nettype none
module flash_access_sva #(
  parameter ADDR_W = 13,
  parameter DATA_W = 14
) (
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              lockFuse,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic              flashRdEn,
  input wire logic              flashWrEn,
  input wire logic [DATA_W-1:0] flashWrData,
  input wire logic              flashWrDone,
  input wire logic              coreStall
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_stall_tracks_prog:
    assert property (coreStall == flashWrEn) else $error("stall differs from program");
  a_locked_no_prog:
    assert property ($rose(flashWrEn) |-> $past(lockFuse, 4)) else $error("write while locked");
  a_done_ends_prog:
    assert property (flashWrEn && flashWrDone |=> !flashWrEn && !coreStall)
    else $error("program not ended");
  a_prog_holds_on:
    assert property (flashWrEn && !flashWrDone |=> flashWrEn) else $error("program aborted");
  a_prog_stable:
    assert property (flashWrEn && $past(flashWrEn) |-> $stable(flashWrData) && $stable(flashAddr))
    else $error("program word changed");
  a_read_window:
    assert property ($rose(flashRdEn) |-> flashRdEn [*5] ##[1:4] !flashRdEn)
    else $error("read window length");
  a_read_not_prog:
    assert property (flashRdEn |-> !flashWrEn) else $error("read during program");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_err_with_ready:
    assert property (pslverr |-> pready) else $error("error without ready");
  a_idle_rdata_zero:
    assert property (!pready |-> prdata == 32'h0) else $error("read data not zero");
endmodule
bind program_flash_self_access flash_access_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
  .clk_sys(clk_sys), .rst(rst), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .lockFuse(lockFuse), .flashAddr(flashAddr), .flashRdEn(flashRdEn),
  .flashWrEn(flashWrEn), .flashWrData(flashWrData), .flashWrDone(flashWrDone),
  .coreStall(coreStall));
`default_nettype wire

// ===== tb.sv
`include "flash_self_access_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        lockFuse = 1'b1, pready, pslverr, rerr, flashRdEn, flashWrEn, flashWrDone;
  logic        coreStall;
  logic [7:0]  paddr = 8'h00, progLen = 8'h04;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [12:0] flashAddr, addr;
  logic [13:0] flashRdData, flashWrData, word;
  int          n_fail = 0, checks_done = 0, cyc = 0, n, seed = 32'h6AB0C08A;
  program_flash_self_access dut_u (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .lockFuse(lockFuse), .flashAddr(flashAddr), .flashRdEn(flashRdEn),
    .flashRdData(flashRdData), .flashWrEn(flashWrEn), .flashWrData(flashWrData),
    .flashWrDone(flashWrDone), .coreStall(coreStall));
  flash_array_model mem_u (
    .clk_sys(clk_sys), .rst(rst), .flashAddr(flashAddr), .flashRdEn(flashRdEn),
    .flashRdData(flashRdData), .flashWrEn(flashWrEn), .flashWrData(flashWrData),
    .flashWrDone(flashWrDone), .progLen(progLen));
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      final_report;
    end
  end
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [13:0] init_word(input logic [12:0] a);
    return a * 14'h7 + 14'h3;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd_word(input logic [12:0] a);
    apb(1'b1, `OFF_ADDR_LO, {24'h0, a[7:0]});
    apb(1'b1, `OFF_ADDR_HI, {27'h0, a[12:8]});
    apb(1'b1, `OFF_CTRL, 32'h81);
    repeat (8) @(posedge clk_sys);
    apb(1'b0, `OFF_CTRL, 32'h0);
    chk(rdat, 32'h80);
    apb(1'b0, `OFF_DATA_LO, 32'h0);
    word[7:0] = rdat[7:0];
    apb(1'b0, `OFF_DATA_HI, 32'h0);
    word[13:8] = rdat[5:0];
  endtask
  // Modes: 0 good, 1 arm with go, 2 keys swapped, 3 fuse low, 4 select clear
  task automatic prog(input int mode, input logic [12:0] a, input logic [13:0] w);
    int k;
    apb(1'b1, `OFF_ADDR_LO, {24'h0, a[7:0]});
    apb(1'b1, `OFF_ADDR_HI, {27'h0, a[12:8]});
    apb(1'b1, `OFF_DATA_LO, {24'h0, w[7:0]});
    apb(1'b1, `OFF_DATA_HI, {26'h0, w[13:8]});
    lockFuse <= (mode != 3);
    apb(1'b1, `OFF_CTRL, mode == 1 ? 32'h80 : 32'h84);
    apb(1'b1, `OFF_KEY, mode == 2 ? 32'hAA : 32'h55);
    apb(1'b1, `OFF_KEY, mode == 2 ? 32'h55 : 32'hAA);
    apb(1'b1, `OFF_CTRL, mode == 4 ? 32'h06 : 32'h86);
    for (k = 0; k < 12 && flashWrEn !== 1'b1; k++)
      @(posedge clk_sys);
    chk({coreStall, flashWrEn}, {2{mode == 0}});
    if (mode == 0) begin
      apb(1'b1, `OFF_CTRL, 32'h80);
      apb(1'b0, `OFF_CTRL, 32'h0);
      chk(rdat, 32'h82);
      for (k = 0; k < 300 && flashWrEn !== 1'b0; k++)
        @(posedge clk_sys);
    end
    if (mode == 3) begin
      apb(1'b0, `OFF_CTRL, 32'h0);
      chk(rdat, 32'h8C);
    end
    lockFuse <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd_word(a);
    chk(word, mode == 0 ? w : init_word(a));
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, `OFF_CTRL, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    for (n = 0; n < 6; n++) begin
      addr = 13'($random(seed));
      rd_word(addr);
      chk(word, init_word(addr));
    end
    apb(1'b1, `OFF_DATA_LO, 32'h5A);
    apb(1'b1, `OFF_CTRL, 32'h01);
    repeat (10) @(posedge clk_sys);
    apb(1'b0, `OFF_DATA_LO, 32'h0);
    chk(rdat, 32'h5A);
    for (n = 0; n < 10; n++) begin
      progLen <= 8'h08 | 8'($random(seed) & 32'h3F); // Long enough to clear arm mid-write
      prog(n % 5, 13'(256 + n), 14'($random(seed)));
    end
    final_report;
  end
endmodule
`default_nettype wire
